// >>> include/ofs_pkg.sv
package ofs_pkg;

    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned PHASES           = 4;
    localparam int unsigned VW               = 12;
    // Millivolt window thresholds
    localparam logic [VW-1:0] OV_MARGIN_MV   = 12'h0fa;
    localparam logic [VW-1:0] UV_MARGIN_MV   = 12'h15e;
    // Event counter latch threshold and decrement period in PWM cycles
    localparam int unsigned OV_LATCH_COUNT   = 16;
    localparam int unsigned OV_DEC_PWM_CYC   = 4096;
    localparam int unsigned OV_DEC_TICKS     = OV_DEC_PWM_CYC * 8;
    // Power-good stretch after overvoltage ends
    localparam int unsigned PG_HOLD_US       = 500;
    localparam int unsigned PG_HOLD_CYC      = PG_HOLD_US * CLK_MHZ;
    // Slew rates in uV per us; one millivolt step per interval
    localparam int unsigned SS_RATE_UV_US    = 800;
    localparam int unsigned DVID_RATE_UV_US  = 3250;
    localparam int unsigned SS_STEP_CYC      = (1000 * CLK_MHZ) / SS_RATE_UV_US;
    localparam int unsigned DVID_STEP_CYC    = (1000 * CLK_MHZ) / DVID_RATE_UV_US;

    typedef struct packed {
        logic [PHASES-1:0] pwm_low;
        logic [PHASES-1:0] pwm_hiz;
        logic              bridge_pwm_low;
        logic              bridge_pwm_hiz;
    } pwm_ctl_t;

    typedef struct packed {
        logic core_ocp;
        logic bridge_ocp;
        logic uvlo_5v;
        logic uvlo_12v;
    } fault_in_t;

    typedef enum logic [1:0] {
        ST_OFF   = 2'b00,
        ST_SOFT  = 2'b01,
        ST_RUN   = 2'b10,
        ST_LATCH = 2'b11
    } seq_state_t;

endpackage : ofs_pkg

// >>> src/output_fault_supervisor.sv
// Functional notes
// RL1: Output 250 mV above target: power good low, PWM low, core driver stays on.
// RL2: Each new overvoltage event increments the event counter by one.
// RL3: Counter reaching threshold latches overvoltage until reset or enable cycle; the code also clears it on supply lockout.
// RL4: Overvoltage clearing before latch resumes normal PWM operation.
// RL5: Eight-times-PWM tick decrements the counter every 4096 PWM cycles.
// RL6: Output 350 mV below target holds power good low only.
// RL7: Start-up ramps core target to boot code at 0.8 mV/us; bridge only serial.
// RL8: After system power ok, new codes slew the target at 3.25 mV/us.
// RL9: Per-phase current limit forces only that phase low.
// RL10: Infrequent overvoltage: PWM low while present, power good stretched 500 us.
// RL11: Frequent overvoltage latches PWM and power good low, drivers unaffected.
// RL12: Supply undervoltage: PWM high-Z, power good and drivers low till recovery.
// RL13: Core driver enable held low: power good low, core target 0 V, pull-up.
// RL14: Bridge driver enable held low: power good low, bridge target 0 V, pull-up.
// RL15: Enable low: PWM high-Z, power good and drivers low; no phase re-sample.
// RL16: Global overcurrent latches and pulls outputs and soft-start low.
// RL17: Per-phase trip acts cycle by cycle, never drops core driver enable.
// RL18: Core or bridge overcurrent: PWM high-Z, latch power good, drivers low.
// RL19: Latch threshold is a parameter.
`timescale 1ns/100ps
`default_nettype none
module output_fault_supervisor #(
    parameter int unsigned OV_LATCH    = ofs_pkg::OV_LATCH_COUNT,
    parameter int unsigned PG_HOLD     = ofs_pkg::PG_HOLD_CYC,
    parameter int unsigned PWM_DIV     = 75
) (
    input  wire logic                         clk,
    input  wire logic                         resetn,
    input  wire logic                         enable,
    input  wire logic                         system_power_ok,
    input  wire logic                         serial_voltage_code_mode,
    input  wire logic [ofs_pkg::VW-1:0]       core_vout_mv,
    input  wire logic [ofs_pkg::VW-1:0]       bridge_vout_mv,
    input  wire logic [ofs_pkg::VW-1:0]       boot_code_mv,
    input  wire logic [ofs_pkg::VW-1:0]       core_code_mv,
    input  wire logic [ofs_pkg::VW-1:0]       bridge_code_mv,
    input  wire logic [ofs_pkg::PHASES-1:0]   phase_trip,
    input  wire logic [ofs_pkg::PHASES-1:0]   phase_strap,
    input  wire ofs_pkg::fault_in_t           faults,
    input  wire logic                         core_driver_enable_in,
    input  wire logic                         bridge_driver_enable_in,
    output var  ofs_pkg::pwm_ctl_t            pwm_ctl,
    output logic                              power_good_out,
    output logic                              core_driver_enable,
    output logic                              core_driver_enable_oe,
    output logic                              core_pullup_en,
    output logic                              bridge_driver_enable,
    output logic                              bridge_driver_enable_oe,
    output logic                              bridge_pullup_en,
    output logic [ofs_pkg::VW-1:0]            core_target_mv,
    output logic [ofs_pkg::VW-1:0]            bridge_target_mv,
    output logic [ofs_pkg::PHASES-1:0]        phase_active
);
    localparam logic [15:0] DEC_TICKS = 16'(ofs_pkg::OV_DEC_TICKS);
    localparam logic [4:0]  OV_TH     = 5'(OV_LATCH);
    localparam logic [18:0] PG_HOLD_W = 19'(PG_HOLD);
    localparam logic [7:0]  DIV_W     = 8'(PWM_DIV - 1);
    localparam logic [7:0]  SS_W      = 8'(ofs_pkg::SS_STEP_CYC - 1);
    localparam logic [7:0]  DV_W      = 8'(ofs_pkg::DVID_STEP_CYC - 1);

    function automatic logic [ofs_pkg::VW-1:0] slew(input logic [ofs_pkg::VW-1:0] cur,
                                                    input logic [ofs_pkg::VW-1:0] tgt);
        if (cur < tgt) begin
            slew = cur + 12'h001;
        end else if (cur > tgt) begin
            slew = cur - 12'h001;
        end else begin
            slew = cur;
        end
    endfunction : slew

    ofs_pkg::seq_state_t state_ff;
    ofs_pkg::seq_state_t nxt_state;
    logic [4:0]  ov_cnt_ff;
    logic        ov_prev_ff;
    logic        ov_latch_ff;
    logic        ocp_latch_ff;
    logic        straps_taken_ff;
    logic [18:0] pg_hold_ff;
    logic [7:0]  div_ff;
    logic [15:0] dec_ff;
    logic [7:0]  step_ff;

    // Comparisons against the present target
    wire [12:0] ov_lim    = {1'b0, core_target_mv} + {1'b0, ofs_pkg::OV_MARGIN_MV};
    wire        ov_now    = {1'b0, core_vout_mv} >= ov_lim;                              // RL1
    wire        uv_now    = {1'b0, core_vout_mv} + {1'b0, ofs_pkg::UV_MARGIN_MV}
                            < {1'b0, core_target_mv};                                    // RL6
    wire        ov_rise   = ov_now && !ov_prev_ff && state_ff == ofs_pkg::ST_RUN;        // RL2
    wire        uvlo      = faults.uvlo_5v || faults.uvlo_12v;                           // RL12
    wire        ocp_now   = faults.core_ocp || faults.bridge_ocp;                        // RL16
    wire        core_ext  = !core_driver_enable_in && core_driver_enable;                // RL13
    wire        brg_ext   = !bridge_driver_enable_in && bridge_driver_enable;            // RL14
    wire        ext_low   = core_ext || brg_ext;
    wire        shutdown  = uvlo || !enable;                                             // RL15
    wire        pwm_tick  = div_ff == DIV_W;                                             // RL5
    wire        dec_tick  = pwm_tick && dec_ff == DEC_TICKS - 16'h0001;                  // RL5
    // Compare with >= so a rate switch never waits for the counter to wrap
    wire        step_tick = step_ff >= (system_power_ok && state_ff == ofs_pkg::ST_RUN
                                       ? DV_W : SS_W);
    wire        cnt_hit   = ov_rise && (ov_cnt_ff + 5'h01 >= OV_TH);                    // RL3 RL11 RL19
    wire [ofs_pkg::VW-1:0] core_goal = (ext_low) ? '0 :
                           (state_ff == ofs_pkg::ST_RUN && system_power_ok)
                           ? core_code_mv : boot_code_mv;                                // RL7 RL8 RL13
    wire [ofs_pkg::VW-1:0] brg_goal  = (ext_low || !serial_voltage_code_mode) ? '0 :
                           (state_ff == ofs_pkg::ST_RUN && system_power_ok)
                           ? bridge_code_mv : boot_code_mv;                              // RL7 RL14
    wire        ramp_done = core_target_mv == core_goal && bridge_target_mv == brg_goal;
    wire        pg_ok     = state_ff == ofs_pkg::ST_RUN && !ov_now && !uv_now && !ext_low
                            && pg_hold_ff == '0 && !shutdown;                            // RL10

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ofs_pkg::ST_OFF:   nxt_state = shutdown ? ofs_pkg::ST_OFF : ofs_pkg::ST_SOFT;
            ofs_pkg::ST_SOFT:  nxt_state = ramp_done && !ext_low ? ofs_pkg::ST_RUN
                                                                 : ofs_pkg::ST_SOFT;
            ofs_pkg::ST_RUN:   nxt_state = (ocp_now || cnt_hit) ? ofs_pkg::ST_LATCH
                                         : ext_low ? ofs_pkg::ST_SOFT : ofs_pkg::ST_RUN; // RL13
            ofs_pkg::ST_LATCH: nxt_state = ofs_pkg::ST_LATCH;
        endcase
        if (shutdown) begin
            nxt_state = ofs_pkg::ST_OFF;                                                 // RL3 RL18
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_ff <= ofs_pkg::ST_OFF;
            div_ff   <= '0;
            dec_ff   <= '0;
            step_ff  <= '0;
        end else begin
            state_ff <= nxt_state;
            div_ff   <= pwm_tick ? 8'h00 : div_ff + 8'h01;
            dec_ff   <= !pwm_tick ? dec_ff : (dec_tick ? 16'h0000 : dec_ff + 16'h0001);
            step_ff  <= step_tick ? 8'h00 : step_ff + 8'h01;
        end
    end

    // Event counter; a new event in the decrement cycle nets to no change unless the count is zero
    always_ff @(posedge clk) begin
        if (!resetn || shutdown) begin
            ov_cnt_ff  <= '0;
            ov_prev_ff <= 1'b0;
        end else begin
            ov_prev_ff <= ov_now;
            if (ov_rise && !(dec_tick && ov_cnt_ff != '0)) begin
                ov_cnt_ff <= (ov_cnt_ff == 5'h1f) ? ov_cnt_ff : ov_cnt_ff + 5'h01;       // RL2
            end else if (dec_tick && !ov_rise && ov_cnt_ff != '0) begin
                ov_cnt_ff <= ov_cnt_ff - 5'h01;                                          // RL5
            end
        end
    end

    // Latches persist until enable drops or supplies fail
    always_ff @(posedge clk) begin
        if (!resetn || shutdown) begin
            ov_latch_ff  <= 1'b0;
            ocp_latch_ff <= 1'b0;
        end else begin
            if (cnt_hit) begin
                ov_latch_ff <= 1'b1;                                                     // RL3 RL11
            end
            if (ocp_now && state_ff != ofs_pkg::ST_OFF) begin
                ocp_latch_ff <= 1'b1;                                                    // RL16 RL18
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pg_hold_ff <= '0;
        end else if (ov_now) begin
            pg_hold_ff <= PG_HOLD_W;                                                     // RL10
        end else if (pg_hold_ff != '0) begin
            pg_hold_ff <= pg_hold_ff - 19'h00001;
        end
    end

    // Phase count sampled only at reset release or after supply lockout
    always_ff @(posedge clk) begin
        if (!resetn || uvlo) begin
            straps_taken_ff <= 1'b0;                                                     // RL12
            phase_active    <= '0;
        end else if (!straps_taken_ff) begin
            straps_taken_ff <= 1'b1;
            phase_active    <= phase_strap;                                              // RL15
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || shutdown || ocp_latch_ff || ocp_now) begin
            core_target_mv   <= '0;                                                      // RL16
            bridge_target_mv <= '0;
        end else if (step_tick) begin
            core_target_mv   <= slew(core_target_mv, core_goal);                         // RL7 RL8
            bridge_target_mv <= slew(bridge_target_mv, brg_goal);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            pwm_ctl                 <= '0;
            power_good_out          <= 1'b0;
            core_driver_enable      <= 1'b0;
            bridge_driver_enable    <= 1'b0;
            core_driver_enable_oe   <= 1'b0;
            bridge_driver_enable_oe <= 1'b0;
            core_pullup_en          <= 1'b0;
            bridge_pullup_en        <= 1'b0;
        end else begin
            // Tri-state wins over forced low
            pwm_ctl.pwm_hiz        <= (shutdown || ocp_latch_ff || ocp_now)
                                      ? '1 : ~phase_active;                              // RL12 RL15 RL18
            pwm_ctl.bridge_pwm_hiz <= shutdown || ocp_latch_ff || ocp_now;
            pwm_ctl.pwm_low        <= (ov_now || ov_latch_ff || cnt_hit)
                                      ? '1 : phase_trip;                                 // RL1 RL4 RL9 RL17
            pwm_ctl.bridge_pwm_low <= ov_now || ov_latch_ff || cnt_hit;                  // RL11
            power_good_out         <= pg_ok && !ov_latch_ff && !ocp_latch_ff && !cnt_hit; // RL6 RL11
            // Drivers are open-drain style: pull low actively, release high
            core_driver_enable      <= !(shutdown || ocp_latch_ff || ocp_now);           // RL1 RL17 RL18
            bridge_driver_enable    <= !(shutdown || ocp_latch_ff || ocp_now);
            core_driver_enable_oe   <= shutdown || ocp_latch_ff || ocp_now;
            bridge_driver_enable_oe <= shutdown || ocp_latch_ff || ocp_now;
            core_pullup_en          <= !core_driver_enable_in && !shutdown;              // RL13
            bridge_pullup_en        <= !bridge_driver_enable_in && !shutdown;            // RL14
        end
    end

endmodule : output_fault_supervisor
`default_nettype wire

// >>> tb/ofs_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ofs_properties (
    input wire logic                       clk,
    input wire logic                       resetn,
    input wire logic                       enable,
    input wire logic [ofs_pkg::VW-1:0]     core_vout_mv,
    input wire logic [ofs_pkg::PHASES-1:0] phase_trip,
    input wire ofs_pkg::fault_in_t         faults,
    input wire logic                       core_driver_enable_in,
    input wire logic                       bridge_driver_enable_in,
    input wire ofs_pkg::pwm_ctl_t          pwm_ctl,
    input wire logic                       power_good_out,
    input wire logic                       core_driver_enable_oe,
    input wire logic                       core_pullup_en,
    input wire logic                       bridge_driver_enable_oe,
    input wire logic                       bridge_pullup_en,
    input wire logic [ofs_pkg::VW-1:0]     core_target_mv
);
    logic [1:0] up_ff;
    // Outputs are forced to zero just after release, so skip those edges
    wire settled = up_ff == 2'h3;
    wire calm    = settled && enable && faults == 4'h0;
    wire ov_now  = {1'b0, core_vout_mv} >= {1'b0, core_target_mv} + 13'(ofs_pkg::OV_MARGIN_MV);
    wire uv_now  = {1'b0, core_vout_mv} + 13'(ofs_pkg::UV_MARGIN_MV) < {1'b0, core_target_mv};
    wire drv_on  = core_driver_enable_oe && bridge_driver_enable_oe;
    always_ff @(posedge clk) begin
        if (!resetn) up_ff <= 2'h0;
        else if (!settled) up_ff <= up_ff + 2'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence ov_hit; calm && power_good_out && ov_now; endsequence
    sequence pg_held; !power_good_out [*8]; endsequence
    a_enable_low_off: assert property (settled && !enable |=>
        pwm_ctl.pwm_hiz == 4'hf && !power_good_out && drv_on) else $error("enable low not off");
    a_uvlo_all_off: assert property (settled && (faults.uvlo_5v || faults.uvlo_12v) |=>
        pwm_ctl.pwm_hiz == 4'hf && pwm_ctl.bridge_pwm_hiz && !power_good_out && drv_on)
        else $error("supply lockout not off");
    a_ocp_latch_hold: assert property (settled && enable && $fell(faults.core_ocp ||
        faults.bridge_ocp) && !faults.uvlo_5v && !faults.uvlo_12v |=> !power_good_out && drv_on)
        else $error("overcurrent not latched");
    a_trip_phase_low: assert property (calm && phase_trip != 4'h0 && !core_driver_enable_oe |=>
        ((pwm_ctl.pwm_low | pwm_ctl.pwm_hiz) & $past(phase_trip)) == $past(phase_trip)
        && !core_driver_enable_oe) else $error("phase trip response wrong");
    a_ov_pwm_low: assert property (ov_hit |=> (pwm_ctl.pwm_low | pwm_ctl.pwm_hiz) == 4'hf
        && !power_good_out && !core_driver_enable_oe) else $error("overvoltage response wrong");
    a_ov_pg_stretch: assert property (ov_hit |=> pg_held)
        else $error("power good not stretched");
    a_uv_pg_low: assert property (calm && uv_now |=> !power_good_out)
        else $error("undervoltage left power good high");
    a_core_hold_pull: assert property (calm && !core_driver_enable_oe &&
        !core_driver_enable_in |=> core_pullup_en && !power_good_out) else $error("core hold");
    a_bridge_hold_pull: assert property (calm && !bridge_driver_enable_oe &&
        !bridge_driver_enable_in |=> bridge_pullup_en && !power_good_out) else $error("bridge hold");
endmodule : ofs_properties
`default_nettype wire

// >>> tb/ofs_driver_pins.sv
`timescale 1ns/100ps
`default_nettype none
module ofs_driver_pins (
    input  wire logic core_oe,
    input  wire logic bridge_oe,
    input  wire logic core_hold_low,
    input  wire logic bridge_hold_low,
    output logic      core_pin,
    output logic      bridge_pin
);
    // Pins have pull-ups; either party may pull them low
    assign core_pin   = !(core_oe || core_hold_low);
    assign bridge_pin = !(bridge_oe || bridge_hold_low);
endmodule : ofs_driver_pins
`default_nettype wire

// >>> tb/test_output_fault_supervisor.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %s exp=%0h got=%0h", nm, e, g); end end
module test_output_fault_supervisor;
    localparam int          PGH  = 20;
    localparam int          DV   = 360 * ofs_pkg::DVID_STEP_CYC;
    localparam logic [11:0] BOOT = 12'h008;
    logic               clk = 1'b0, resetn = 1'b0, enable = 1'b0;
    logic               system_power_ok = 1'b0, serial_voltage_code_mode = 1'b1;
    logic [11:0]        core_vout_mv = 12'h000, bridge_vout_mv = 12'h000;
    logic [11:0]        boot_code_mv = BOOT, core_code_mv = BOOT, bridge_code_mv = BOOT;
    logic [3:0]         phase_trip = 4'h0, phase_strap = 4'hf, s, phase_active;
    logic [1:0]         hold = 2'h0;
    ofs_pkg::fault_in_t faults = 4'h0;
    ofs_pkg::pwm_ctl_t  pwm_ctl;
    logic [11:0]        core_target_mv, bridge_target_mv;
    logic               power_good_out, core_driver_enable_oe, core_pullup_en;
    logic               bridge_driver_enable_oe, bridge_pullup_en;
    wire logic          core_driver_enable_in, bridge_driver_enable_in;
    int                 off = 0, n = 0, n_fail = 0, tests_run = 0;
    output_fault_supervisor #(.PG_HOLD(PGH), .PWM_DIV(2)) dut_u (.clk, .resetn, .enable,
        .system_power_ok, .serial_voltage_code_mode, .core_vout_mv, .bridge_vout_mv,
        .boot_code_mv, .core_code_mv, .bridge_code_mv, .phase_trip, .phase_strap, .faults,
        .core_driver_enable_in, .bridge_driver_enable_in, .pwm_ctl, .power_good_out,
        .core_driver_enable(), .core_driver_enable_oe, .core_pullup_en,
        .bridge_driver_enable(), .bridge_driver_enable_oe, .bridge_pullup_en,
        .core_target_mv, .bridge_target_mv, .phase_active);
    ofs_driver_pins pins_u (.core_oe(core_driver_enable_oe), .bridge_oe(bridge_driver_enable_oe),
        .core_hold_low(hold[0]), .bridge_hold_low(hold[1]), .core_pin(core_driver_enable_in),
        .bridge_pin(bridge_driver_enable_in));
    always #2.5 clk = ~clk;
    function automatic logic [11:0] track(input logic [11:0] t, input int d);
        return (int'(t) + d < 0) ? 12'h000 : 12'(int'(t) + d);
    endfunction : track
    function automatic int ss_lim(input logic [11:0] mv);
        return int'(mv) * ofs_pkg::SS_STEP_CYC + 64;
    endfunction : ss_lim
    always @(negedge clk) begin
        core_vout_mv <= track(core_target_mv, off);
        bridge_vout_mv <= bridge_target_mv;
    end
    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc
    task automatic wait_pg();
        n = 0;
        while (power_good_out !== 1'b1 && n < ss_lim(BOOT)) begin
            cyc(1);
            n++;
        end
        `CHK("pg_up", 1'b1, power_good_out)
    endtask : wait_pg
    task automatic restart();
        enable <= 1'b0;
        cyc(3);
        enable <= 1'b1;
        wait_pg();
    endtask : restart
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    initial begin
        repeat (90000) @(posedge clk);
        n_fail++;
        close_out();
    end
    initial begin
        void'($urandom(26));
        cyc(4);
        resetn <= 1'b1;
        cyc(4);
        `CHK("off_state", 6'h3f, {pwm_ctl.pwm_hiz, core_driver_enable_oe, bridge_driver_enable_oe})
        enable <= 1'b1;
        wait_pg();
        `CHK("boot_tgt", {BOOT, BOOT}, {core_target_mv, bridge_target_mv})
        $display("test start done");
        for (int i = 0; i < 8; i++) begin
            s = (i == 0) ? 4'hf : 4'($urandom_range(15));
            phase_trip <= s;
            off <= int'($urandom_range(200)) - 100;
            cyc(2);
            `CHK("trip_low", s, pwm_ctl.pwm_low)
            `CHK("trip_pg_drv", 1'b1, power_good_out && !core_driver_enable_oe)
        end
        phase_trip <= 4'h0;
        off <= 249;
        cyc(4);
        `CHK("ov_below", 1'b1, power_good_out)
        for (int i = 1; i <= ofs_pkg::OV_LATCH_COUNT; i++) begin
            off <= 250;
            cyc(3);
            `CHK("ov_hit", 6'h3c, {pwm_ctl.pwm_low, power_good_out, core_driver_enable_oe})
            off <= 0;
            cyc(PGH - 2);
            `CHK("ov_stretch", 1'b0, power_good_out)
            cyc(12);
            `CHK("ov_latch", i == ofs_pkg::OV_LATCH_COUNT, pwm_ctl.pwm_low[0])
            `CHK("ov_resume", i != ofs_pkg::OV_LATCH_COUNT, power_good_out)
        end
        phase_strap <= 4'h3;
        restart();
        `CHK("ov_clear_strap", 8'h0f, {pwm_ctl.pwm_low, phase_active})
        $display("test overvoltage done");
        for (int i = 0; i < 2; i++) begin
            hold[i] <= 1'b1;
            cyc(ss_lim(BOOT));
            `CHK("hold_pg", 1'b0, power_good_out)
            `CHK("hold_pullup", 1'b1, i ? bridge_pullup_en : core_pullup_en)
            `CHK("hold_tgt", 12'h000, i ? bridge_target_mv : core_target_mv)
            hold[i] <= 1'b0;
            wait_pg();
            faults <= i ? 4'h4 : 4'h8;
            cyc(2);
            faults <= 4'h0;
            cyc(4);
            `CHK("ocp_off", 8'hfb, {pwm_ctl.pwm_hiz, pwm_ctl.bridge_pwm_hiz, power_good_out,
                core_driver_enable_oe, bridge_driver_enable_oe})
            restart();
        end
        $display("test hold and overcurrent done");
        for (int i = 0; i < 2; i++) begin
            s = $urandom_range(1) ? 4'h7 : 4'hf;
            faults <= i ? 4'h1 : 4'h2;
            phase_strap <= s;
            cyc(3);
            `CHK("uvlo_off", 8'hfb, {pwm_ctl.pwm_hiz, pwm_ctl.bridge_pwm_hiz, power_good_out,
                core_driver_enable_oe, bridge_driver_enable_oe})
            faults <= 4'h0;
            wait_pg();
            `CHK("strap_new", s, phase_active)
        end
        $display("test lockout done");
        system_power_ok <= 1'b1;
        core_code_mv <= BOOT + 12'h168;
        n = 0;
        while (core_target_mv !== BOOT + 12'h168 && n < DV + 2000) begin
            cyc(1);
            n++;
        end
        `CHK("dvid_rate", 1'b1, n > DV - 200 && n < DV + 200)
        off <= -350;
        cyc(4);
        `CHK("uv_edge", 1'b1, power_good_out)
        off <= -351;
        cyc(4);
        `CHK("uv_low", 6'h00, {power_good_out, core_driver_enable_oe, pwm_ctl.pwm_low & phase_active})
        serial_voltage_code_mode <= 1'b0;
        cyc(8 * ofs_pkg::DVID_STEP_CYC + 200);
        `CHK("brg_parallel", 12'h000, bridge_target_mv)
        $display("test slew and undervoltage done");
        close_out();
    end
endmodule : test_output_fault_supervisor
bind output_fault_supervisor ofs_properties chk_u (.clk, .resetn, .enable, .core_vout_mv,
    .phase_trip, .faults, .core_driver_enable_in, .bridge_driver_enable_in, .pwm_ctl,
    .power_good_out, .core_driver_enable_oe, .core_pullup_en, .bridge_driver_enable_oe,
    .bridge_pullup_en, .core_target_mv);
`default_nettype wire
